/* design/flfm_pkg.sv */
// constants and types for the fault flag and beam mode block
package flfm_pkg;
    // ==============================
    // register map: page and direct address
    localparam logic [4:0] PAGE_FLAG = 5'h1F;
    localparam logic [4:0] PAGE_GATE = 5'h1D;
    localparam logic [2:0] ADDR_BEHAV = 3'h6;
    localparam logic [2:0] ADDR_MASK = 3'h7;
    localparam logic [2:0] ADDR_GATE = 3'h6;
    localparam logic [2:0] ADDR_DUTY = 3'h7;
    // ==============================
    // field positions
    localparam int SHARE_LO = 6;
    localparam int OCF_LO = 4;
    localparam int DLY_LO = 2;
    localparam int HBF_BIT = 1;
    localparam int TEMP_BIT = 0;
    localparam int GATE_POL_BIT = 1;
    localparam int GATE_FORCE_BIT = 0;
    localparam int MASK_W = 6;
    // ==============================
    // reset values
    localparam logic [7:0] BEHAV_RST = 8'h03;
    localparam logic [5:0] MASK_RST = 6'h3F;
    localparam logic [1:0] GATE_RST = 2'h0;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hC8;
    // ==============================
    // timing
    localparam int CLK_HZ = 250_000_000;
    localparam int DLY0_MS = 50;
    localparam int DLY1_MS = 100;
    localparam int DLY2_MS = 1000;
    localparam int DLY3_MS = 2000;
    localparam int DLY0_CYC = DLY0_MS * (CLK_HZ / 1000);
    localparam int DLY1_CYC = DLY1_MS * (CLK_HZ / 1000);
    localparam int DLY2_CYC = DLY2_MS * (CLK_HZ / 1000);
    localparam int DLY3_CYC = DLY3_MS * (CLK_HZ / 1000);
    localparam logic [4:0] OCF0_CYC = 5'h02;
    localparam logic [4:0] OCF1_CYC = 5'h04;
    localparam logic [4:0] OCF2_CYC = 5'h08;
    localparam logic [4:0] OCF3_CYC = 5'h10;
    // ==============================
    // lamp modes
    typedef enum logic [1:0] {MODE_OFF, MODE_DAYTIME, MODE_LOWBEAM, MODE_HIGHBEAM} flfm_mode_type;
endpackage : flfm_pkg

/* design/flfm_persist_if.sv */
// carrier between the block and its persistence counters
`timescale 1ns/1ps
interface flfm_persist_if #(parameter int W = 8);
    logic cond;
    logic [W-1:0] limit;
    logic met;
    modport owner (output cond, output limit, input met);
    modport counter (input cond, input limit, output met);
endinterface : flfm_persist_if

/* design/flfm_persist.sv */
// counts consecutive cycles of a condition and flags when the limit is reached
`timescale 1ns/1ps
module flfm_persist #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // condition and result
    flfm_persist_if.counter pif
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        if (!pif.cond) begin
            cnt_next = '0;
        end else if (cnt_reg >= pif.limit) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // restart on any gap, so only an unbroken run counts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pif.met <= 1'b0;
        end else begin
            pif.met <= pif.cond && (cnt_next >= pif.limit);
        end
    end
endmodule : flfm_persist

/* design/flfm_top.sv */
// fault flag sharing, fault filtering and reporting, lamp mode decode
`timescale 1ns/1ps
// Function
// - A two-bit field picks which flag lines are shared enable/fault lines: none, first, second or both; none at reset.
// - Overcurrent is accepted only after lasting 2, 4, 8 or 16 cycles by code, 2 at reset.
// - The second flag reports after 50, 100, 1000 or 2000 ms by code, 50 ms at reset.
// - A mask bit, one at reset, lets a high-beam fault reach the second flag.
// - A mask bit, one at reset, lets overtemperature reach the second flag.
// - Enable high with dim and beam selects low gives daytime mode with the stored duty clamped to 200.
// - Enable and dim select high with beam select low gives low-beam mode at full duty.
// - All three inputs high gives high-beam mode in boost topology at full duty.
// - Six mask bits, one at reset, let the remaining fault kinds reach the second flag.
// - A polarity bit sets the high-beam gate while beam select is low, and a force bit turns it on.
// - The duty code steps half a percent per count, 200 being full duty.
module flfm_top #(
    parameter int CNT_W = 30,
    parameter int unsigned DLY0_CYC = flfm_pkg::DLY0_CYC,
    parameter int unsigned DLY1_CYC = flfm_pkg::DLY1_CYC,
    parameter int unsigned DLY2_CYC = flfm_pkg::DLY2_CYC,
    parameter int unsigned DLY3_CYC = flfm_pkg::DLY3_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // configuration port, written over the serial link or from stored memory
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [4:0] cfg_page,
    input wire logic [2:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // lamp select pins
    input wire logic enable_in,
    input wire logic dim_select_n,
    input wire logic beam_select_n,
    // fault detectors
    input wire logic fault_vreg_uv,
    input wire logic fault_out_ov,
    input wire logic fault_out_uv,
    input wire logic fault_out_oc,
    input wire logic fault_open_led,
    input wire logic fault_str_short,
    input wire logic fault_highbeam,
    input wire logic fault_overtemp,
    // open-drain flag lines
    input wire logic fault_flag_a_n_in,
    output logic fault_flag_a_n_out,
    output logic fault_flag_a_n_oe,
    input wire logic fault_flag_b_n_in,
    output logic fault_flag_b_n_out,
    output logic fault_flag_b_n_oe,
    // power stage control
    output logic switching_en,
    output flfm_pkg::flfm_mode_type lamp_mode,
    output logic boost_topology,
    output logic [7:0] duty_code,
    output logic highbeam_gate_out,
    output logic overcurrent_accepted
);
    // ==============================
    // helpers
    function automatic logic [CNT_W-1:0] dly_count(input logic [1:0] code);
        case (code)
            2'h0: dly_count = CNT_W'(DLY0_CYC);
            2'h1: dly_count = CNT_W'(DLY1_CYC);
            2'h2: dly_count = CNT_W'(DLY2_CYC);
            default: dly_count = CNT_W'(DLY3_CYC);
        endcase
    endfunction : dly_count

    function automatic logic [4:0] ocf_count(input logic [1:0] code);
        case (code)
            2'h0: ocf_count = flfm_pkg::OCF0_CYC;
            2'h1: ocf_count = flfm_pkg::OCF1_CYC;
            2'h2: ocf_count = flfm_pkg::OCF2_CYC;
            default: ocf_count = flfm_pkg::OCF3_CYC;
        endcase
    endfunction : ocf_count

    function automatic logic [7:0] duty_clamp(input logic [7:0] code);
        duty_clamp = (code > flfm_pkg::DUTY_FULL) ? flfm_pkg::DUTY_FULL : code;
    endfunction : duty_clamp

    // ==============================
    // configuration registers
    logic [7:0] behav_reg;
    logic [5:0] mask_reg;
    logic [1:0] gate_reg;
    logic [7:0] duty_reg;
    logic sel_behav, sel_mask, sel_gate, sel_duty;
    logic [1:0] share_sel;

    assign sel_behav = (cfg_page == flfm_pkg::PAGE_FLAG) && (cfg_addr == flfm_pkg::ADDR_BEHAV);
    assign sel_mask = (cfg_page == flfm_pkg::PAGE_FLAG) && (cfg_addr == flfm_pkg::ADDR_MASK);
    assign sel_gate = (cfg_page == flfm_pkg::PAGE_GATE) && (cfg_addr == flfm_pkg::ADDR_GATE);
    assign sel_duty = (cfg_page == flfm_pkg::PAGE_GATE) && (cfg_addr == flfm_pkg::ADDR_DUTY);
    assign share_sel = behav_reg[flfm_pkg::SHARE_LO +: 2];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            behav_reg <= flfm_pkg::BEHAV_RST;
            mask_reg <= flfm_pkg::MASK_RST;
            gate_reg <= flfm_pkg::GATE_RST;
            duty_reg <= flfm_pkg::DUTY_RST;
        end else if (cfg_wr) begin
            if (sel_behav) behav_reg <= cfg_wdata;
            if (sel_mask) mask_reg <= cfg_wdata[flfm_pkg::MASK_W-1:0];
            if (sel_gate) gate_reg <= cfg_wdata[1:0];
            if (sel_duty) duty_reg <= cfg_wdata;
        end
    end

    // unmapped addresses and reserved bits read as zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= sel_behav ? behav_reg :
                         sel_mask ? {2'h0, mask_reg} :
                         sel_gate ? {6'h00, gate_reg} :
                         sel_duty ? duty_reg : 8'h00;
        end
    end

    // ==============================
    // pin synchronisers
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] sync1_reg, sync2_reg;
    logic en_s, dim_s, beam_s, oc_s, hb_s, temp_s, line_a_s, line_b_s;
    logic [5:0] six_s;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {fault_flag_b_n_in, fault_flag_a_n_in, enable_in, dim_select_n, beam_select_n,
                          fault_highbeam, fault_overtemp, fault_vreg_uv, fault_out_ov, fault_out_uv,
                          fault_out_oc, fault_open_led, fault_str_short};
            sync2_reg <= sync1_reg;
        end
    end

    assign {line_b_s, line_a_s, en_s, dim_s, beam_s, hb_s, temp_s} = sync2_reg[12:6];
    assign six_s = sync2_reg[5:0];
    assign oc_s = sync2_reg[2];

    // ==============================
    // overcurrent filter and second flag delay
    flfm_persist_if #(.W(5)) ocf_if ();
    flfm_persist_if #(.W(CNT_W)) dly_if ();
    logic [5:0] six_acc;
    logic unmasked_b, fault_any;

    assign ocf_if.cond = oc_s;
    assign ocf_if.limit = ocf_count(behav_reg[flfm_pkg::OCF_LO +: 2]);
    assign six_acc = {six_s[5:3], ocf_if.met, six_s[1:0]};
    assign unmasked_b = (|(six_acc & mask_reg))
                      | (hb_s & behav_reg[flfm_pkg::HBF_BIT])
                      | (temp_s & behav_reg[flfm_pkg::TEMP_BIT]);
    assign fault_any = (|six_acc) | hb_s | temp_s;
    assign dly_if.cond = unmasked_b;
    assign dly_if.limit = dly_count(behav_reg[flfm_pkg::DLY_LO +: 2]);

    flfm_persist #(.W(5)) u_ocf (.ref_clk(ref_clk), .sys_rst(sys_rst), .pif(ocf_if.counter));
    flfm_persist #(.W(CNT_W)) u_dly (.ref_clk(ref_clk), .sys_rst(sys_rst), .pif(dly_if.counter));

    // ==============================
    // flag line drive and sharing
    logic [2:0] hist_a_reg, hist_b_reg;
    logic peer_low_a, peer_low_b;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_flag_a_n_oe <= 1'b0;
            fault_flag_b_n_oe <= 1'b0;
            overcurrent_accepted <= 1'b0;
        end else begin
            fault_flag_a_n_oe <= fault_any;
            fault_flag_b_n_oe <= dly_if.met;
            overcurrent_accepted <= ocf_if.met;
        end
    end

    assign fault_flag_a_n_out = 1'b0;
    assign fault_flag_b_n_out = 1'b0;

    // own drive echoes back through the synchroniser, so mask it for that long
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hist_a_reg <= '0;
            hist_b_reg <= '0;
        end else begin
            hist_a_reg <= {hist_a_reg[1:0], fault_flag_a_n_oe};
            hist_b_reg <= {hist_b_reg[1:0], fault_flag_b_n_oe};
        end
    end

    assign peer_low_a = share_sel[0] && !line_a_s && !fault_flag_a_n_oe && !(|hist_a_reg);
    assign peer_low_b = share_sel[1] && !line_b_s && !fault_flag_b_n_oe && !(|hist_b_reg);

    // ==============================
    // lamp mode decode
    flfm_pkg::flfm_mode_type mode_next;

    always_comb begin
        if (!en_s) begin
            mode_next = flfm_pkg::MODE_OFF;
        end else if (!dim_s) begin
            mode_next = flfm_pkg::MODE_DAYTIME;
        end else if (!beam_s) begin
            mode_next = flfm_pkg::MODE_LOWBEAM;
        end else begin
            mode_next = flfm_pkg::MODE_HIGHBEAM;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lamp_mode <= flfm_pkg::MODE_OFF;
            boost_topology <= 1'b0;
            duty_code <= 8'h00;
            switching_en <= 1'b0;
        end else begin
            lamp_mode <= mode_next;
            boost_topology <= (mode_next == flfm_pkg::MODE_HIGHBEAM);
            case (mode_next)
                flfm_pkg::MODE_DAYTIME: duty_code <= duty_clamp(duty_reg);
                flfm_pkg::MODE_LOWBEAM: duty_code <= flfm_pkg::DUTY_FULL;
                flfm_pkg::MODE_HIGHBEAM: duty_code <= flfm_pkg::DUTY_FULL;
                default: duty_code <= 8'h00;
            endcase
            switching_en <= (mode_next != flfm_pkg::MODE_OFF) && !peer_low_a && !peer_low_b;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            highbeam_gate_out <= 1'b0;
        end else begin
            highbeam_gate_out <= gate_reg[flfm_pkg::GATE_FORCE_BIT] | beam_s
                               | gate_reg[flfm_pkg::GATE_POL_BIT];
        end
    end

    // ==============================
    // checks
    logic [CNT_W-1:0] hold_cnt;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= unmasked_b ? hold_cnt + CNT_W'(1) : '0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_share_off_idle: assert property (share_sel == 2'h0 |-> !peer_low_a && !peer_low_b)
        else $error("peer low seen with sharing off");
    a_oc_filter_run: assert property ($rose(ocf_if.met) |-> $past(oc_s, 1) && $past(oc_s, 2))
        else $error("overcurrent accepted too early");
    a_flag_b_delay: assert property ($rose(dly_if.met) |-> hold_cnt >= dly_if.limit)
        else $error("second flag before delay");
    a_hb_mask_gate: assert property (!behav_reg[1] && hb_s && !temp_s && six_acc == 6'h00 |-> !unmasked_b)
        else $error("masked high-beam fault reported");
    a_temp_mask_gate: assert property (behav_reg[0] && temp_s |-> unmasked_b)
        else $error("overtemperature not reported");
    a_daytime_mode: assert property (en_s && !dim_s |=> lamp_mode == flfm_pkg::MODE_DAYTIME
                                     && duty_code == duty_clamp($past(duty_reg)))
        else $error("daytime mode wrong");
    a_lowbeam_mode: assert property (en_s && dim_s && !beam_s |=> lamp_mode == flfm_pkg::MODE_LOWBEAM
                                     && !boost_topology && duty_code == flfm_pkg::DUTY_FULL)
        else $error("low-beam mode wrong");
    a_highbeam_mode: assert property (en_s && dim_s && beam_s |=> boost_topology
                                      && duty_code == flfm_pkg::DUTY_FULL)
        else $error("high-beam mode wrong");
    a_other_mask_gate: assert property (mask_reg == 6'h00 && !hb_s && !temp_s |-> !unmasked_b)
        else $error("masked fault reported");
    a_gate_polarity: assert property (!gate_reg[0] && !gate_reg[1] && !beam_s |=> !highbeam_gate_out)
        else $error("high-beam gate on unexpectedly");
    a_duty_range: assert property (duty_code <= flfm_pkg::DUTY_FULL)
        else $error("duty code above full");
    a_peer_stop: assert property (peer_low_a || peer_low_b |=> !switching_en)
        else $error("switching kept on with line held low");
    a_flag_b_drop: assert property (!unmasked_b |=> ##1 !fault_flag_b_n_oe)
        else $error("second flag held after fault cleared");

    c_daytime: cover property (lamp_mode == flfm_pkg::MODE_DAYTIME);
    c_highbeam: cover property ($rose(boost_topology));
    c_flag_b: cover property ($rose(fault_flag_b_n_oe));
    c_peer_low: cover property (peer_low_a ##1 !peer_low_a);
endmodule : flfm_top

/* tb/flfm_peer.sv */
// peer driver model on the two shared open-drain fault flag lines
`timescale 1ns/1ps
module flfm_peer (
    // device side of each line
    input wire logic dev_out_a,
    input wire logic dev_oe_a,
    input wire logic dev_out_b,
    input wire logic dev_oe_b,
    // peer fault commands from the bench
    input wire logic pull_a,
    input wire logic pull_b,
    // resolved line levels
    output logic line_a,
    output logic line_b
);
    // ==============================
    // wired-and with pull-up: a peer only sinks, so a released line reads high
    assign line_a = !((dev_oe_a && !dev_out_a) || pull_a);
    assign line_b = !((dev_oe_b && !dev_out_b) || pull_b);
endmodule : flfm_peer

/* tb/flfm_top_tb.sv */
// self-checking bench for the fault flag and lamp mode block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module flfm_top_tb;
    typedef struct {logic en; logic dim; logic beam; flfm_pkg::flfm_mode_type mode; logic boost; logic [7:0] duty; logic gate;} flfm_row_type;
    logic ref_clk, sys_rst, cfg_wr, cfg_rd, enable_in, dim_select_n, beam_select_n, pull_a, pull_b;
    logic [4:0] cfg_page;
    logic [2:0] cfg_addr;
    logic [7:0] cfg_wdata, cfg_rdata, flt, duty_code, en;
    logic a_in, a_out, a_oe, b_in, b_out, b_oe, switching_en, boost_topology, highbeam_gate_out, overcurrent_accepted;
    flfm_pkg::flfm_mode_type lamp_mode;
    int fails, tests_run, n, m;
    int dly[4] = '{20, 40, 80, 160};
    int ocf[4] = '{2, 4, 8, 16};
    flfm_row_type rows[6] = '{
        '{1'h0, 1'h0, 1'h0, flfm_pkg::MODE_OFF, 1'h0, 8'h00, 1'h0},
        '{1'h1, 1'h0, 1'h0, flfm_pkg::MODE_DAYTIME, 1'h0, 8'h64, 1'h0},
        '{1'h1, 1'h1, 1'h0, flfm_pkg::MODE_LOWBEAM, 1'h0, 8'hC8, 1'h0},
        '{1'h1, 1'h1, 1'h1, flfm_pkg::MODE_HIGHBEAM, 1'h1, 8'hC8, 1'h1},
        '{1'h1, 1'h0, 1'h1, flfm_pkg::MODE_DAYTIME, 1'h0, 8'h64, 1'h1},
        '{1'h0, 1'h1, 1'h1, flfm_pkg::MODE_OFF, 1'h0, 8'h00, 1'h1}};

    flfm_top #(.DLY0_CYC(20), .DLY1_CYC(40), .DLY2_CYC(80), .DLY3_CYC(160)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_page(cfg_page), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .enable_in(enable_in), .dim_select_n(dim_select_n), .beam_select_n(beam_select_n),
        .fault_vreg_uv(flt[7]), .fault_out_ov(flt[6]), .fault_out_uv(flt[5]), .fault_out_oc(flt[4]),
        .fault_open_led(flt[3]), .fault_str_short(flt[2]), .fault_highbeam(flt[1]), .fault_overtemp(flt[0]),
        .fault_flag_a_n_in(a_in), .fault_flag_a_n_out(a_out), .fault_flag_a_n_oe(a_oe),
        .fault_flag_b_n_in(b_in), .fault_flag_b_n_out(b_out), .fault_flag_b_n_oe(b_oe),
        .switching_en(switching_en), .lamp_mode(lamp_mode), .boost_topology(boost_topology),
        .duty_code(duty_code), .highbeam_gate_out(highbeam_gate_out), .overcurrent_accepted(overcurrent_accepted));
    flfm_peer peer (.dev_out_a(a_out), .dev_oe_a(a_oe), .dev_out_b(b_out), .dev_oe_b(b_oe),
        .pull_a(pull_a), .pull_b(pull_b), .line_a(a_in), .line_b(b_in));

    // ==============================
    // clock and watchdog
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end

    // ==============================
    // tasks
    task automatic conclude();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic wr(input logic [4:0] p, input logic [2:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cfg_page = p;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'h1;
        @(negedge ref_clk);
        cfg_wr = 1'h0;
    endtask : wr
    task automatic rd_chk(input logic [4:0] p, input logic [2:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        cfg_page = p;
        cfg_addr = a;
        cfg_rd = 1'h1;
        @(negedge ref_clk);
        cfg_rd = 1'h0;
        @(negedge ref_clk);
        `CHK(cfg_rdata, e)
    endtask : rd_chk
    // counts falling edges until the chosen output is high, giving up at lim
    task automatic wait_rise(input int w, input int lim, output int k);
        k = 0;
        while (!((w == 0 && overcurrent_accepted === 1'h1) || (w == 1 && a_oe === 1'h1) ||
                 (w == 2 && b_oe === 1'h1)) && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
    endtask : wait_rise

    // ==============================
    // main sequence
    initial begin
        {sys_rst, cfg_wr, cfg_rd, cfg_page, cfg_addr, cfg_wdata} = {1'h1, 18'h00000};
        {enable_in, dim_select_n, beam_select_n, pull_a, pull_b, flt} = 13'h0000;
        fails = 0;
        tests_run = 0;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'h0;
        `CHK(lamp_mode, flfm_pkg::MODE_OFF)
        rd_chk(5'h1F, 3'h6, 8'h03);
        rd_chk(5'h1F, 3'h7, 8'h3F);
        rd_chk(5'h1D, 3'h6, 8'h00);
        rd_chk(5'h1D, 3'h7, 8'h00);
        wr(5'h1F, 3'h6, 8'hC3);
        rd_chk(5'h1F, 3'h6, 8'hC3);
        wr(5'h1F, 3'h7, 8'hFF);
        rd_chk(5'h1F, 3'h7, 8'h3F);
        wr(5'h1D, 3'h6, 8'hFF);
        rd_chk(5'h1D, 3'h6, 8'h03);
        wr(5'h00, 3'h0, 8'h55);
        rd_chk(5'h00, 3'h0, 8'h00);
        wr(5'h1F, 3'h6, 8'h03);
        wr(5'h1D, 3'h6, 8'h00);
        wr(5'h1D, 3'h7, 8'h64);
        foreach (rows[i]) begin
            {enable_in, dim_select_n, beam_select_n} = {rows[i].en, rows[i].dim, rows[i].beam};
            repeat (4) @(negedge ref_clk);
            `CHK(lamp_mode, rows[i].mode)
            `CHK(boost_topology, rows[i].boost)
            `CHK(duty_code, rows[i].duty)
            `CHK(highbeam_gate_out, rows[i].gate)
        end
        // awkward cases: duty clamp, gate polarity and force with beam select low
        {enable_in, dim_select_n, beam_select_n} = 3'h4;
        wr(5'h1D, 3'h7, 8'hFF);
        repeat (4) @(negedge ref_clk);
        `CHK(duty_code, 8'hC8)
        for (int g = 3; g >= 0; g--) begin
            wr(5'h1D, 3'h6, g[7:0]);
            repeat (2) @(negedge ref_clk);
            `CHK(highbeam_gate_out, g != 0)
        end
        // overcurrent filter length per code, then a pulse one cycle too short
        for (int c = 0; c < 4; c++) begin
            wr(5'h1F, 3'h6, {2'h0, c[1:0], 4'h3});
            flt[4] = 1'h1;
            wait_rise(0, 60, n);
            flt = 8'h00;
            `CHK(n, ocf[c] + 3)
            repeat (10) @(negedge ref_clk);
        end
        flt[4] = 1'h1;
        repeat (15) @(negedge ref_clk);
        flt[4] = 1'h0;
        wait_rise(0, 25, n);
        `CHK(n, 25)
        // second flag delay per code, own fault pulling the line low
        for (int c = 0; c < 4; c++) begin
            wr(5'h1F, 3'h6, {4'h0, c[1:0], 2'h3});
            flt[0] = 1'h1;
            wait_rise(1, 8, n);
            `CHK(a_in, 1'h0)
            wait_rise(2, 400, m);
            `CHK(b_in, 1'h0)
            `CHK(n + m, dly[c] + 3)
            flt = 8'h00;
            repeat (6) @(negedge ref_clk);
            `CHK({a_oe, b_oe}, 2'h0)
        end
        wr(5'h1F, 3'h6, 8'h03);
        flt[0] = 1'h1;
        repeat (15) @(negedge ref_clk);
        flt[0] = 1'h0;
        repeat (4) @(negedge ref_clk);
        flt[0] = 1'h1;
        wait_rise(2, 400, m);
        `CHK(m, dly[0] + 3)
        flt = 8'h00;
        // each mask alone lets its fault through; clearing it alone blocks it
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                en = (p == 0) ? (8'h01 << i) : ~(8'h01 << i);
                wr(5'h1F, 3'h7, {2'h0, en[7:2]});
                wr(5'h1F, 3'h6, {6'h00, en[1:0]});
                repeat (8) @(negedge ref_clk);
                flt = 8'h01 << i;
                wait_rise(2, 60, m);
                `CHK(m < 60, p == 0)
                `CHK(a_oe, 1'h1)
                flt = 8'h00;
            end
        end
        // shared lines pulled from outside in every sharing code
        repeat (8) @(negedge ref_clk);
        `CHK(switching_en, 1'h1)
        for (int s = 0; s < 4; s++) begin
            wr(5'h1F, 3'h6, {s[1:0], 6'h03});
            for (int l = 0; l < 2; l++) begin
                {pull_a, pull_b} = (l == 0) ? 2'h2 : 2'h1;
                repeat (6) @(negedge ref_clk);
                `CHK(switching_en, !s[l])
                {pull_a, pull_b} = 2'h0;
                repeat (6) @(negedge ref_clk);
                `CHK(switching_en, 1'h1)
            end
        end
        // reset in mid-run brings back defaults
        sys_rst = 1'h1;
        repeat (2) @(negedge ref_clk);
        `CHK({lamp_mode, a_oe, b_oe}, 4'h0)
        sys_rst = 1'h0;
        rd_chk(5'h1F, 3'h6, 8'h03);
        rd_chk(5'h1F, 3'h7, 8'h3F);
        conclude();
    end
endmodule : flfm_top_tb
